// ===== verilog/timer_pkg.sv
// constants, register map and carrier types for the counter and prescaler block
// What this block does
// - clock source select 0 counts instruction cycles, 1 counts count-pin transitions
// - any counter write blocks counting for the next two instruction cycles
// - edge select 0 counts rising pin edges, 1 counts falling edges
// - counter wrapping from FFh to 00h sets the overflow flag
// - overflow request is passed on only while overflow enable is set
// - counter stops during sleep, so overflow cannot wake the core
// - count input synchronised by sampling prescaler output on two phase clocks
// - shared prescaler serves counter when assign is 0, watchdog when 1
// - counter ratios run 1:2 at code 000 up to 1:256 at 111
// - watchdog ratios run 1:1 up to 1:128, doubling each code
// - prescaler not accessible; counter write clears it when assigned to counter
// - watchdog clear instruction clears prescaler when assigned to watchdog
// - pull-up disable 1 turns all pull-ups off, else mask bits apply
// - external irq edge select 1 picks rising edge, 0 falling edge
// - analog-selected pins read 0 as digital inputs; only the count pin (select bit 2) is gated, the interrupt pin is not
`default_nettype none
package timer_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_COUNTER = 8'h01;
    localparam logic [7:0] ADDR_INTCTL = 8'h0B;
    localparam logic [7:0] ADDR_INTCTL_B1 = 8'h8B;
    localparam logic [7:0] ADDR_OPTION = 8'h81;
    localparam logic [7:0] ADDR_PORTA_DIR = 8'h85;
    localparam logic [7:0] ADDR_ANALOG_SEL = 8'h91;
    localparam logic [7:0] ADDR_PULLUP_MASK = 8'h95;
    localparam logic [7:0] RST_INTCTL = 8'h00;
    localparam logic [7:0] RST_OPTION = 8'hFF;
    localparam logic [7:0] RST_PORTA_DIR = 8'h3F;
    localparam logic [7:0] RST_ANALOG_SEL = 8'hFF;
    localparam logic [7:0] RST_PULLUP_MASK = 8'h37;
    localparam logic [7:0] RST_COUNTER = 8'h00;
    localparam logic [7:0] PORTA_MASK = 8'h3F;
    localparam logic [7:0] PULLUP_IMPL = 8'h37;
    localparam logic [7:0] INTCTL_WMASK = 8'hFF;
    localparam int BIT_OVF_FLAG = 2;
    localparam int BIT_OVF_EN = 5;
    localparam int COUNT_PIN_ANALOG_SELECT_BIT = 2;
    localparam int INHIBIT_CYCLES = 2;
    localparam logic [1:0] PHASE_Q1 = 2'h0;
    localparam logic [1:0] PHASE_Q2 = 2'h1;
    localparam logic [1:0] PHASE_Q4 = 2'h3;
    localparam logic [1:0] INHIBIT_LOAD = 2'(INHIBIT_CYCLES);

    typedef struct packed {
        logic pullup_disable_all;
        logic ext_irq_edge_select;
        logic clock_source_select;
        logic source_edge_select;
        logic prescaler_assign;
        logic [2:0] prescale_rate_field;
    } option_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
endpackage
`default_nettype wire

// ===== verilog/prescaler_div.sv
// shared 8-bit prescaler with rate-selected tap
`default_nettype none
module prescaler_div #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic event_in,
    input wire logic clear,
    input wire logic [2:0] rate,
    input wire logic to_watchdog,
    output logic tick_out
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic [2:0] bsel;
    logic bypass;

    assign count_next = clear ? '0 : (event_in ? count_reg + 1'b1 : count_reg);
    // watchdog taps one stage earlier, 1:1 at code 000
    assign bypass = to_watchdog && rate == 3'h0;
    assign bsel = to_watchdog ? rate - 3'h1 : rate;
    // one output per completed division ratio: tap bit falls on this event
    assign tick_out = bypass ? event_in : (count_reg[bsel] && !count_next[bsel] && !clear);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule // prescaler_div

// ===== verilog/timer0_counter_prescaler.sv
// counter, option and interrupt-control registers with edge counting
`default_nettype none
module timer0_counter_prescaler (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic external_count_pin,
    input wire logic external_interrupt_pin,
    input wire logic sleep,
    input wire logic watchdog_clear_instruction,
    output logic overflow_irq,
    output logic ext_irq_edge_event,
    output logic watchdog_tick,
    output logic [5:0] pullup_enable,
    output logic [5:0] port_a_dir_out
);
    timer_pkg::option_t option_reg;
    logic [7:0] counter_reg;
    logic [7:0] intctl_reg;
    logic [7:0] porta_dir_reg;
    logic [7:0] analog_sel_reg;
    logic [7:0] pullup_mask_reg;
    logic [7:0] rdata_reg;
    logic [1:0] inhibit_reg;
    logic [1:0] phase_reg;
    logic pin_s1_reg;
    logic pin_s2_reg;
    logic irq_s1_reg;
    logic irq_s2_reg;
    logic irq_prev_reg;
    logic ps_sample_reg;
    logic ps_hit_reg;
    logic src_prev_reg;

    // register decode
    logic wr_counter;
    logic wr_intctl;
    logic wr_option;
    logic wr_dir;
    logic wr_analog_select;
    logic wr_pullup;
    assign wr_counter = wr && addr == timer_pkg::ADDR_COUNTER;
    assign wr_intctl = wr && (addr == timer_pkg::ADDR_INTCTL || addr == timer_pkg::ADDR_INTCTL_B1);
    assign wr_option = wr && addr == timer_pkg::ADDR_OPTION;
    assign wr_dir = wr && addr == timer_pkg::ADDR_PORTA_DIR;
    assign wr_analog_select = wr && addr == timer_pkg::ADDR_ANALOG_SEL;
    assign wr_pullup = wr && addr == timer_pkg::ADDR_PULLUP_MASK;

    // count pin reads 0 while selected analog
    logic pin_digital;
    assign pin_digital = pin_s2_reg && !analog_sel_reg[timer_pkg::COUNT_PIN_ANALOG_SELECT_BIT];

    // edge select: 1 inverts so a falling pin edge is a rising source edge
    logic src_level;
    logic pin_edge;
    assign src_level = pin_digital ^ option_reg.source_edge_select;
    assign pin_edge = src_level && !src_prev_reg;

    // instruction cycle strobe, one per four clocks
    logic instr_cycle;
    assign instr_cycle = phase_reg == timer_pkg::PHASE_Q4;

    // prescaler source: pin edges or instruction cycles, instruction cycles when assigned to watchdog
    logic to_wdt;
    logic ps_event;
    logic ps_clear;
    logic ps_tick;
    logic counter_src;
    assign to_wdt = option_reg.prescaler_assign;
    assign counter_src = option_reg.clock_source_select ? pin_edge : instr_cycle;
    assign ps_event = to_wdt ? instr_cycle : counter_src;
    assign ps_clear = to_wdt ? watchdog_clear_instruction : wr_counter;

    prescaler_div #(.WIDTH(8)) u_prescaler (
        .clock(clock),
        .resetn(resetn),
        .event_in(ps_event && !sleep),
        .clear(ps_clear),
        .rate(option_reg.prescale_rate_field),
        .to_watchdog(to_wdt),
        .tick_out(ps_tick)
    );

    // without prescaler the raw source feeds the sampler directly
    logic raw_src;
    logic ps_out_level;
    assign raw_src = to_wdt ? counter_src : ps_tick;
    assign ps_out_level = raw_src;

    // increment sampled on q2/q4 phases
    logic sample_phase;
    logic sampled_inc;
    logic pending;
    logic inc_slot;
    assign sample_phase = phase_reg == timer_pkg::PHASE_Q2 || phase_reg == timer_pkg::PHASE_Q4;
    // a pulse between sampling phases is held until the next one
    assign pending = ps_sample_reg || ps_out_level;
    assign sampled_inc = ps_hit_reg;
    // edge on which an instruction-cycle increment lands
    assign inc_slot = phase_reg == timer_pkg::PHASE_Q1;

    logic inc;
    assign inc = sampled_inc && inhibit_reg == 2'h0 && !sleep && !wr_counter;

    logic wrap;
    assign wrap = inc && counter_reg == 8'hFF;

    logic [7:0] counter_next;
    assign counter_next = wr_counter ? wdata : (inc ? counter_reg + 8'h01 : counter_reg);

    logic [7:0] inhibit_dec;
    assign inhibit_dec = {6'h00, inhibit_reg} - 8'h01;

    // flag set wins over software clear
    logic [7:0] intctl_next;
    always_comb begin
        intctl_next = wr_intctl ? (wdata & timer_pkg::INTCTL_WMASK) : intctl_reg;
        if (wrap) begin
            intctl_next[timer_pkg::BIT_OVF_FLAG] = 1'b1;
        end
    end

    // external interrupt edge detect
    logic irq_edge;
    assign irq_edge = option_reg.ext_irq_edge_select ? (irq_s2_reg && !irq_prev_reg)
                    : (!irq_s2_reg && irq_prev_reg);

    // read mux
    logic [7:0] rd_mux;
    always_comb begin
        case (addr)
            timer_pkg::ADDR_COUNTER: rd_mux = counter_reg;
            timer_pkg::ADDR_INTCTL: rd_mux = intctl_reg;
            timer_pkg::ADDR_INTCTL_B1: rd_mux = intctl_reg;
            timer_pkg::ADDR_OPTION: rd_mux = option_reg;
            timer_pkg::ADDR_PORTA_DIR: rd_mux = porta_dir_reg;
            timer_pkg::ADDR_ANALOG_SEL: rd_mux = analog_sel_reg;
            timer_pkg::ADDR_PULLUP_MASK: rd_mux = pullup_mask_reg;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
            irq_s1_reg <= 1'b0;
            irq_s2_reg <= 1'b0;
            irq_prev_reg <= 1'b0;
            src_prev_reg <= 1'b0;
        end else begin
            pin_s1_reg <= external_count_pin;
            pin_s2_reg <= pin_s1_reg;
            irq_s1_reg <= external_interrupt_pin;
            irq_s2_reg <= irq_s1_reg;
            irq_prev_reg <= irq_s2_reg;
            src_prev_reg <= src_level;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            phase_reg <= 2'h0;
            ps_sample_reg <= 1'b0;
            ps_hit_reg <= 1'b0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
            if (sample_phase) begin
                ps_sample_reg <= 1'b0;
                ps_hit_reg <= pending;
            end else begin
                ps_sample_reg <= pending;
                ps_hit_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            counter_reg <= timer_pkg::RST_COUNTER;
            inhibit_reg <= 2'h0;
        end else begin
            counter_reg <= counter_next;
            if (wr_counter) begin
                inhibit_reg <= timer_pkg::INHIBIT_LOAD;
            end else if (inc_slot && inhibit_reg != 2'h0) begin
                inhibit_reg <= inhibit_dec[1:0];
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            intctl_reg <= timer_pkg::RST_INTCTL;
            option_reg <= timer_pkg::RST_OPTION;
            porta_dir_reg <= timer_pkg::RST_PORTA_DIR;
            analog_sel_reg <= timer_pkg::RST_ANALOG_SEL;
            pullup_mask_reg <= timer_pkg::RST_PULLUP_MASK;
            rdata_reg <= 8'h00;
        end else begin
            intctl_reg <= intctl_next;
            if (wr_option) option_reg <= wdata;
            if (wr_dir) porta_dir_reg <= wdata & timer_pkg::PORTA_MASK;
            if (wr_analog_select) analog_sel_reg <= wdata;
            if (wr_pullup) pullup_mask_reg <= wdata & timer_pkg::PULLUP_IMPL;
            rdata_reg <= rd ? rd_mux : 8'h00;
        end
    end

    assign rdata = rdata_reg;
    assign overflow_irq = intctl_reg[timer_pkg::BIT_OVF_FLAG]
                        && intctl_reg[timer_pkg::BIT_OVF_EN];
    assign ext_irq_edge_event = irq_edge;
    assign watchdog_tick = to_wdt && ps_tick && !sleep;
    assign pullup_enable = option_reg.pullup_disable_all ? 6'h00
                         : pullup_mask_reg[5:0];
    assign port_a_dir_out = porta_dir_reg[5:0];
endmodule // timer0_counter_prescaler
`default_nettype wire

// ===== sim/timer0_counter_prescaler_assertions.sv
// port assertions for the counter and prescaler block
`default_nettype none
module timer0_counter_prescaler_assertions (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic sleep,
    input wire logic watchdog_clear_instruction,
    input wire logic overflow_irq,
    input wire logic ext_irq_edge_event,
    input wire logic watchdog_tick,
    input wire logic [5:0] pullup_enable,
    input wire logic [5:0] port_a_dir_out
);
    logic [3:0] opt_reg;
    logic quiet;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            opt_reg <= 4'hF;
        else if (wr && addr == timer_pkg::ADDR_OPTION)
            opt_reg <= wdata[3:0];
    end
    // watchdog owns prescaler at 1:1, nothing disturbing it
    assign quiet = !sleep && !wr && !watchdog_clear_instruction && opt_reg == 4'h8;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_q3; quiet [*3]; endsequence
    sequence s_nap; (sleep && !wr) [*3]; endsequence
    property p_rd_idle; !rd |=> rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_dir; wr && addr == timer_pkg::ADDR_PORTA_DIR |=>
        {2'b00, port_a_dir_out} == ($past(wdata) & timer_pkg::PORTA_MASK); endproperty
    a_dir: assert property (p_dir) else $error("direction not written");
    property p_pu_off; wr && addr == timer_pkg::ADDR_OPTION && wdata[7] |=>
        pullup_enable == 6'h00; endproperty
    a_pu_off: assert property (p_pu_off) else $error("pull-ups not off");
    property p_mask; wr && addr == timer_pkg::ADDR_INTCTL && !wdata[5] |=> !overflow_irq;
    endproperty
    a_mask: assert property (p_mask) else $error("irq not masked");
    property p_keep; overflow_irq && !wr |=> overflow_irq; endproperty
    a_keep: assert property (p_keep) else $error("irq dropped by itself");
    property p_nap; s_nap |-> !$rose(overflow_irq); endproperty
    a_nap: assert property (p_nap) else $error("overflow during sleep");
    property p_own; watchdog_tick |-> opt_reg[3] || $past(opt_reg[3]); endproperty
    a_own: assert property (p_own) else $error("tick while unassigned");
    property p_wrate; (watchdog_tick && quiet) ##1 s_q3 |=> watchdog_tick; endproperty
    a_wrate: assert property (p_wrate) else $error("postscale 1:1 late");
    property p_ext; ext_irq_edge_event |=> !ext_irq_edge_event; endproperty
    a_ext: assert property (p_ext) else $error("edge event too long");
endmodule // timer0_counter_prescaler_assertions
`default_nettype wire

// ===== sim/count_source.sv
// pulse source for the external count pin
`default_nettype none
module count_source (
    input wire logic clock,
    input wire logic go,
    input wire logic [7:0] edges,
    input wire logic [7:0] hold,
    output logic pin,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        pin = 1'b0;
        busy = 1'b0;
    end
    always @(posedge clock) begin
        if (go && !busy) begin
            busy <= 1'b1;
            for (int i = 0; i < edges; i++) begin
                repeat ((hold < 2) ? 2 : hold) @(posedge clock);
                pin <= !pin;
            end
            busy <= 1'b0;
        end
    end
endmodule // count_source
`default_nettype wire

// ===== sim/tb.sv
// testbench for the counter and prescaler block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, resetn, wr, rd, int_pin, sleep, wclr, go, cnt_pin, busy;
    logic [7:0] addr, wdata, rdata, a, v, edges, hold;
    logic [5:0] pullup_enable, port_a_dir_out;
    logic overflow_irq, ext_irq_edge_event, watchdog_tick;
    int n_fail, cmp_count, n;
    timer0_counter_prescaler uut (.clock(clock), .resetn(resetn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .external_count_pin(cnt_pin),
        .external_interrupt_pin(int_pin), .sleep(sleep), .watchdog_clear_instruction(wclr),
        .overflow_irq(overflow_irq), .ext_irq_edge_event(ext_irq_edge_event),
        .watchdog_tick(watchdog_tick), .pullup_enable(pullup_enable),
        .port_a_dir_out(port_a_dir_out));
    count_source src (.clock(clock), .go(go), .edges(edges), .hold(hold), .pin(cnt_pin),
        .busy(busy));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wd_clear;
        wclr <= 1'b1;
        @(posedge clock);
        wclr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rreg(input logic [7:0] ad, output logic [7:0] d);
        addr <= ad;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge clock);
    endtask
    // wait for watchdog_tick, give up after lim edges
    task automatic until_tick(input int lim);
        for (n = 1; n <= lim && watchdog_tick !== 1'b1; n++) @(posedge clock);
        if (n > lim) chk("tick wait", 16'h0, 16'h1);
        if (n > lim) final_report();
    endtask
    task automatic pulses(input logic [7:0] e, input logic [7:0] h);
        edges <= e;
        hold <= h;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        for (n = 0; n < 300 && (n == 0 || busy); n++) @(posedge clock);
        repeat (12) @(posedge clock);
    endtask
    task automatic events(input logic lvl, input int exp);
        int c;
        c = 0;
        int_pin <= lvl;
        repeat (10) begin
            @(posedge clock);
            if (ext_irq_edge_event === 1'b1) c++;
        end
        chk("edge events", 16'(c), 16'(exp));
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        resetn = 1'b0;
        {wr, rd, int_pin, sleep, wclr, go, addr, wdata, edges, hold} = '0;
        n_fail = 0;
        cmp_count = 0;
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        rreg(timer_pkg::ADDR_INTCTL, v);
        chk("intctl reset", v, timer_pkg::RST_INTCTL);
        rreg(timer_pkg::ADDR_OPTION, v);
        chk("option reset", v, timer_pkg::RST_OPTION);
        rreg(timer_pkg::ADDR_PORTA_DIR, v);
        chk("dir reset", v, timer_pkg::RST_PORTA_DIR);
        rreg(8'h55, v);
        chk("unmapped", v, 8'h00);
        wreg(timer_pkg::ADDR_PORTA_DIR, 8'h15);
        chk("dir out", port_a_dir_out, 8'h15 & timer_pkg::PORTA_MASK);
        $display("test reset done");
        wreg(timer_pkg::ADDR_OPTION, 8'h28);
        wreg(timer_pkg::ADDR_COUNTER, 8'h00);
        pulses(8'd4, 8'd4);
        rreg(timer_pkg::ADDR_COUNTER, v);
        chk("analog pin count", v, 8'h00);
        chk("pullups", pullup_enable, timer_pkg::PULLUP_IMPL[5:0]);
        wreg(timer_pkg::ADDR_ANALOG_SEL, 8'h00);
        wreg(timer_pkg::ADDR_COUNTER, 8'h00);
        pulses(8'd5, 8'd3);
        rreg(timer_pkg::ADDR_COUNTER, v);
        chk("rising count", v, 8'h03);
        wreg(timer_pkg::ADDR_OPTION, 8'h38);
        wreg(timer_pkg::ADDR_COUNTER, 8'h00);
        pulses(8'd5, 8'd9);
        rreg(timer_pkg::ADDR_COUNTER, v);
        chk("falling count", v, 8'h03);
        $display("test counter mode done");
        wreg(timer_pkg::ADDR_OPTION, 8'h08);
        rreg(timer_pkg::ADDR_COUNTER, a);
        repeat (38) @(posedge clock);
        rreg(timer_pkg::ADDR_COUNTER, v);
        chk("timer rate", 8'(v - a), 8'd10);
        wreg(timer_pkg::ADDR_COUNTER, 8'h10);
        repeat (39) @(posedge clock);
        rreg(timer_pkg::ADDR_COUNTER, v);
        chk("write inhibit", v, 8'h18);
        sleep <= 1'b1;
        rreg(timer_pkg::ADDR_COUNTER, a);
        repeat (40) @(posedge clock);
        rreg(timer_pkg::ADDR_COUNTER, v);
        chk("sleep hold", v, a);
        sleep <= 1'b0;
        wreg(timer_pkg::ADDR_INTCTL, 8'h20);
        wreg(timer_pkg::ADDR_COUNTER, 8'hFE);
        for (n = 0; n < 100 && overflow_irq !== 1'b1; n++) @(posedge clock);
        rreg(timer_pkg::ADDR_INTCTL, v);
        chk("overflow flag", v, 8'h24);
        chk("irq passed", overflow_irq, 1'b1);
        wreg(timer_pkg::ADDR_INTCTL, 8'h04);
        chk("irq masked", overflow_irq, 1'b0);
        repeat (100) @(posedge clock);
        rreg(timer_pkg::ADDR_INTCTL, v);
        chk("flag kept", v, 8'h04);
        wreg(timer_pkg::ADDR_INTCTL, 8'h00);
        $display("test timer mode done");
        for (int ps = 0; ps < 8; ps++) begin
            wd_clear();
            wreg(timer_pkg::ADDR_OPTION, 8'(ps));
            wreg(timer_pkg::ADDR_COUNTER, 8'h00);
            repeat (8) @(posedge clock);
            rreg(timer_pkg::ADDR_COUNTER, a);
            repeat ((16 << ps) - 2) @(posedge clock);
            rreg(timer_pkg::ADDR_COUNTER, v);
            chk("prescale", 8'(v - a), 8'd2);
            wd_clear();
            wreg(timer_pkg::ADDR_COUNTER, 8'h00);
            wreg(timer_pkg::ADDR_OPTION, 8'h08 | 8'(ps));
            until_tick(1100);
            @(posedge clock);
            until_tick(1100);
            chk("postscale", 16'(n), 16'(4 << ps));
        end
        repeat (100) @(posedge clock);
        wclr <= 1'b1;
        @(posedge clock);
        wclr <= 1'b0;
        until_tick(1100);
        chk("clear delays tick", 16'(n >= 508), 16'h1);
        $display("test prescaler done");
        for (int e = 0; e < 2; e++) begin
            wreg(timer_pkg::ADDR_OPTION, 8'h88 | 8'(e << 6));
            events(1'b1, e);
            events(1'b0, 1 - e);
        end
        $display("test interrupt edge done");
        final_report();
    end
endmodule // tb
bind timer0_counter_prescaler timer0_counter_prescaler_assertions chk_i (.clock(clock),
    .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sleep(sleep), .watchdog_clear_instruction(watchdog_clear_instruction),
    .overflow_irq(overflow_irq), .ext_irq_edge_event(ext_irq_edge_event),
    .watchdog_tick(watchdog_tick), .pullup_enable(pullup_enable),
    .port_a_dir_out(port_a_dir_out));
`default_nettype wire
